/* File: relay_contact_model.sv */
// Relay on one output terminal pair, as seen by the lift controller
`timescale 1ns/100ps
module relay_contact_model (
  input  wire pos_i,
  input  wire neg_i,
  output wire closed_o
);
  // Coil sees the pair differentially, so equal levels leave the contact open
  assign closed_o = pos_i & ~neg_i;
endmodule // relay_contact_model

/* File: status_output_selector.v */
// Routes internal drive status conditions onto three multifunction output terminals
`timescale 1ns/100ps
`include "status_output_selector_defines.vh"

// Overview of operation
// - Three terminal pairs with own selection code; reset codes 0, 1, 2.
// - Code 0 is ON while run command active or output voltage present.
// - Code 37 is ON only while frequency output; OFF in baseblock, injection, stop.
// - Code 1 is ON below zero-speed level: 0.1, 0.5 or 1.2 Hz by mode.
// - Code 43 is the inverse of zero speed.
// - Code 6 turns ON once startup initialisation finished without a fault.
// - Code 7 is ON while DC bus undervoltage is detected.
// - Code 8 is ON while the power stage is in baseblock.
// - Code 9 ON when panel gives frequency reference; code A when panel gives run.
// - Code E ON for major faults except two processor fault codes; minor ignored.
// - Code 10 is ON while a minor fault is present.
// - Code 11 is ON while a fault reset input is present.
// - Code 1A ON while reverse run commanded, also in injection and baseblock.
// - Code 1B is OFF while a baseblock command input is asserted.
// - Code 1C is OFF with motor 1 data and ON with motor 2 data.
// - Code 1D is ON while the motor regenerates.
// - Code 40 closes while the brake sequence asks to release the brake.
// - Code 41 closes while the brake sequence asks the contactors to close.
// - Code 38 is ON while any heatsink fan runs.
// - Code 42 ON above door-zone threshold in deceleration; OFF when travel released.
// - Codes 46 and 47 switch state when both block inputs are enabled.
module status_output_selector #(
  parameter         FREQ_W      = 16,
  parameter [7:0]   CPU_FAULT_A = 8'h01,
  parameter [7:0]   CPU_FAULT_B = 8'h02
) (
  input  wire              clock_i,
  input  wire              rst_b_i,
  // Register port
  input  wire [2:0]        reg_addr_i,
  input  wire [15:0]       reg_wdata_i,
  input  wire              reg_wr_i,
  input  wire              reg_rd_i,
  output reg  [15:0]       reg_rdata_o,
  // Digital input pins
  input  wire              output_block_input_1_i,
  input  wire              output_block_input_2_i,
  input  wire              motor2_select_pin_i,
  input  wire              fault_reset_pin_i,
  // Internal drive state
  input  wire              run_cmd_i,
  input  wire              voltage_out_i,
  input  wire              freq_out_i,
  input  wire              dc_injection_i,
  input  wire              baseblock_i,
  input  wire [FREQ_W-1:0] output_freq_i,
  input  wire [FREQ_W-1:0] motor_speed_i,
  input  wire              init_done_i,
  input  wire              undervoltage_i,
  input  wire              fref_panel_i,
  input  wire              run_src_panel_i,
  input  wire              major_fault_i,
  input  wire [7:0]        fault_code_i,
  input  wire              minor_fault_i,
  input  wire              reverse_run_i,
  input  wire              regen_i,
  input  wire              brake_release_req_i,
  input  wire              contactor_close_req_i,
  input  wire              fan_running_i,
  input  wire              decel_i,
  input  wire              travel_cmd_i,
  // Terminal outputs
  output reg               output_a_pos_o,
  output reg               output_a_neg_o,
  output reg               output_b_pos_o,
  output reg               output_b_neg_o,
  output reg               output_c_pos_o,
  output reg               output_c_neg_o,
  output reg               motor2_active_o
);

  localparam NUM_PINS = 4;
  localparam COND_W_L = `COND_W;

  reg  [7:0]          sel_a;
  reg  [7:0]          sel_b;
  reg  [7:0]          sel_c;
  reg  [1:0]          ctrl_mode;
  reg  [FREQ_W-1:0]   door_threshold;
  reg                 ready;
  reg  [NUM_PINS-1:0] pin_meta;
  reg  [NUM_PINS-1:0] pin_sync;
  wire [NUM_PINS-1:0] pin_raw;
  wire                block_1;
  wire                block_2;
  wire                motor2_sel;
  wire                fault_rst;
  reg  [FREQ_W-1:0]   zero_level;
  wire                zero_speed;
  wire [FREQ_W-1:0]   door_speed;
  wire                door_zone;
  wire                major_counted;
  wire [COND_W_L-1:0] cond;
  wire [2:0]          term_next;

  assign pin_raw = {fault_reset_pin_i, motor2_select_pin_i,
                    output_block_input_2_i, output_block_input_1_i};

  // Pins are asynchronous to the control clock
  // One process drives both vectors, so each register has a single driver
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_meta <= {NUM_PINS{1'b0}};
      pin_sync <= {NUM_PINS{1'b0}};
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  assign block_1    = pin_sync[0];
  assign block_2    = pin_sync[1];
  assign motor2_sel = pin_sync[2];
  assign fault_rst  = pin_sync[3];

  always @* begin
    case (ctrl_mode)
      `MODE_CLV:    zero_level = `ZERO_LEVEL_CLOSED;
      `MODE_CLV_PM: zero_level = `ZERO_LEVEL_CLOSED;
      `MODE_OLV:    zero_level = `ZERO_LEVEL_OPEN;
      default:      zero_level = `ZERO_LEVEL_VF;
    endcase
  end

  assign zero_speed = (output_freq_i < zero_level);

  assign door_speed = ((ctrl_mode == `MODE_CLV) || (ctrl_mode == `MODE_CLV_PM)) ?
                      motor_speed_i : output_freq_i;
  assign door_zone  = travel_cmd_i & decel_i & (door_speed > door_threshold);

  assign major_counted = major_fault_i &
                         (fault_code_i != CPU_FAULT_A) &
                         (fault_code_i != CPU_FAULT_B);

  // ready once init done with no fault
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ready <= 1'b0;
    end else if (major_fault_i) begin
      ready <= 1'b0;
    end else if (init_done_i) begin
      ready <= 1'b1;
    end
  end

  assign cond[`C_RUN]    = run_cmd_i | voltage_out_i;
  assign cond[`C_ZERO]   = zero_speed;
  assign cond[`C_READY]  = ready;
  assign cond[`C_UV]     = undervoltage_i;
  assign cond[`C_BB]     = baseblock_i;
  assign cond[`C_FREF]   = fref_panel_i;
  assign cond[`C_RUNSRC] = run_src_panel_i;
  assign cond[`C_FAULT]  = major_counted;
  assign cond[`C_MINOR]  = minor_fault_i;
  assign cond[`C_FRST]   = fault_rst;
  assign cond[`C_REV]    = reverse_run_i;
  assign cond[`C_BBCMD]  = ~(block_1 | block_2);
  assign cond[`C_MOTOR2] = motor2_active_o;
  assign cond[`C_REGEN]  = regen_i;
  assign cond[`C_RUN2]   = freq_out_i & ~baseblock_i & ~dc_injection_i;
  assign cond[`C_FAN]    = fan_running_i;
  assign cond[`C_BRAKE]  = brake_release_req_i;
  assign cond[`C_CONT]   = contactor_close_req_i;
  assign cond[`C_DOOR]   = door_zone;
  assign cond[`C_BOTHBB] = block_1 & block_2;

  // Shared by all three terminals
  function route;
    input [7:0]          code;
    input [COND_W_L-1:0] c;
    begin
      case (code)
        `FN_DURING_RUN:     route = c[`C_RUN];
        `FN_ZERO_SPEED:     route = c[`C_ZERO];
        `FN_READY:          route = c[`C_READY];
        `FN_UNDERVOLTAGE:   route = c[`C_UV];
        `FN_BASEBLOCK:      route = c[`C_BB];
        `FN_FREF_PANEL:     route = c[`C_FREF];
        `FN_RUN_PANEL:      route = c[`C_RUNSRC];
        `FN_FAULT:          route = c[`C_FAULT];
        `FN_MINOR_FAULT:    route = c[`C_MINOR];
        `FN_FAULT_RESET:    route = c[`C_FRST];
        `FN_REVERSE:        route = c[`C_REV];
        `FN_BASEBLOCK_2:    route = c[`C_BBCMD];
        `FN_MOTOR2:         route = c[`C_MOTOR2];
        `FN_REGEN:          route = c[`C_REGEN];
        `FN_DURING_RUN_2:   route = c[`C_RUN2];
        `FN_FAN:            route = c[`C_FAN];
        `FN_BRAKE_RELEASE:  route = c[`C_BRAKE];
        `FN_CONTACTOR:      route = c[`C_CONT];
        `FN_DOOR_ZONE:      route = c[`C_DOOR];
        `FN_NOT_ZERO_SPEED: route = ~c[`C_ZERO];
        // monitor 1 closes, monitor 2 opens
        `FN_BLOCK_MON_1:    route = c[`C_BOTHBB];
        `FN_BLOCK_MON_2:    route = ~c[`C_BOTHBB];
        default:            route = 1'b0;
      endcase
    end
  endfunction

  assign term_next[0] = route(sel_a, cond);
  assign term_next[1] = route(sel_b, cond);
  assign term_next[2] = route(sel_c, cond);

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      output_a_pos_o <= 1'b0;
      output_a_neg_o <= 1'b1;
      output_b_pos_o <= 1'b0;
      output_b_neg_o <= 1'b1;
      output_c_pos_o <= 1'b0;
      output_c_neg_o <= 1'b1;
    end else begin
      output_a_pos_o <= term_next[0];
      output_a_neg_o <= ~term_next[0];
      output_b_pos_o <= term_next[1];
      output_b_neg_o <= ~term_next[1];
      output_c_pos_o <= term_next[2];
      output_c_neg_o <= ~term_next[2];
    end
  end

  // motor data set follows the input
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      motor2_active_o <= 1'b0;
    end else begin
      motor2_active_o <= motor2_sel;
    end
  end

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sel_a          <= `SEL_A_RESET;
      sel_b          <= `SEL_B_RESET;
      sel_c          <= `SEL_C_RESET;
      ctrl_mode      <= `CONTROL_RESET;
      door_threshold <= `DOOR_THRESHOLD_RESET;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `REG_SEL_A) begin
        sel_a <= reg_wdata_i[7:0];
      end else if (reg_addr_i == `REG_SEL_B) begin
        sel_b <= reg_wdata_i[7:0];
      end else if (reg_addr_i == `REG_SEL_C) begin
        sel_c <= reg_wdata_i[7:0];
      end else if (reg_addr_i == `REG_CONTROL) begin
        ctrl_mode <= reg_wdata_i[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
      end else if (reg_addr_i == `REG_DOOR_THRESHOLD) begin
        door_threshold <= reg_wdata_i[FREQ_W-1:0];
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_addr_i == `REG_SEL_A) begin
      reg_rdata_o <= {8'h00, sel_a};
    end else if (reg_addr_i == `REG_SEL_B) begin
      reg_rdata_o <= {8'h00, sel_b};
    end else if (reg_addr_i == `REG_SEL_C) begin
      reg_rdata_o <= {8'h00, sel_c};
    end else if (reg_addr_i == `REG_CONTROL) begin
      reg_rdata_o <= {14'h0000, ctrl_mode};
    end else if (reg_addr_i == `REG_DOOR_THRESHOLD) begin
      reg_rdata_o <= door_threshold;
    end else if (reg_addr_i == `REG_STATUS) begin
      reg_rdata_o <= {11'h000, ready, motor2_active_o,
                      output_c_pos_o, output_b_pos_o, output_a_pos_o};
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

endmodule // status_output_selector

/* File: status_output_selector_defines.vh */
// Constants for the multifunction status output selector
`ifndef STATUS_OUTPUT_SELECTOR_DEFINES_VH
`define STATUS_OUTPUT_SELECTOR_DEFINES_VH

// Register indices on the plain register port
`define REG_SEL_A            3'h0
`define REG_SEL_B            3'h1
`define REG_SEL_C            3'h2
`define REG_CONTROL          3'h3
`define REG_DOOR_THRESHOLD   3'h4
`define REG_STATUS           3'h5

// Reset values of the terminal selection codes, control mode and door threshold
`define SEL_A_RESET          8'h00
`define SEL_B_RESET          8'h01
`define SEL_C_RESET          8'h02
`define CONTROL_RESET        2'h0
`define DOOR_THRESHOLD_RESET 16'h0000

// Control register fields
`define CTRL_MODE_LSB        0
`define CTRL_MODE_MSB        1

// Status register fields
`define STAT_TERM_LSB        0
`define STAT_TERM_MSB        2
`define STAT_MOTOR2_BIT      3
`define STAT_READY_BIT       4

// Control modes
`define MODE_VF              2'h0
`define MODE_OLV             2'h1
`define MODE_CLV             2'h2
`define MODE_CLV_PM          2'h3

// Zero speed levels, frequency in units of 0.01 Hz
`define ZERO_LEVEL_CLOSED    16'h000A
`define ZERO_LEVEL_OPEN      16'h0032
`define ZERO_LEVEL_VF        16'h0078

// Function selection codes
`define FN_DURING_RUN        8'h00
`define FN_ZERO_SPEED        8'h01
`define FN_READY             8'h06
`define FN_UNDERVOLTAGE      8'h07
`define FN_BASEBLOCK         8'h08
`define FN_FREF_PANEL        8'h09
`define FN_RUN_PANEL         8'h0A
`define FN_FAULT             8'h0E
`define FN_MINOR_FAULT       8'h10
`define FN_FAULT_RESET       8'h11
`define FN_REVERSE           8'h1A
`define FN_BASEBLOCK_2       8'h1B
`define FN_MOTOR2            8'h1C
`define FN_REGEN             8'h1D
`define FN_DURING_RUN_2      8'h37
`define FN_FAN               8'h38
`define FN_BRAKE_RELEASE     8'h40
`define FN_CONTACTOR         8'h41
`define FN_DOOR_ZONE         8'h42
`define FN_NOT_ZERO_SPEED    8'h43
`define FN_BLOCK_MON_1       8'h46
`define FN_BLOCK_MON_2       8'h47

// Bit positions in the condition vector
`define C_RUN                0
`define C_ZERO               1
`define C_READY              2
`define C_UV                 3
`define C_BB                 4
`define C_FREF               5
`define C_RUNSRC             6
`define C_FAULT              7
`define C_MINOR              8
`define C_FRST               9
`define C_REV                10
`define C_BBCMD              11
`define C_MOTOR2             12
`define C_REGEN              13
`define C_RUN2               14
`define C_FAN                15
`define C_BRAKE              16
`define C_CONT               17
`define C_DOOR               18
`define C_BOTHBB             19
`define COND_W               20

`endif

/* File: status_output_selector_monitor.sv */
// Concurrent checks on the ports of the status output selector
`timescale 1ns/100ps
module status_output_selector_monitor #(
  parameter       FREQ_W      = 16,
  parameter [7:0] CPU_FAULT_A = 8'h01,
  parameter [7:0] CPU_FAULT_B = 8'h02
) (
  input wire              clock_i,
  input wire              rst_b_i,
  input wire [2:0]        reg_addr_i,
  input wire [15:0]       reg_wdata_i,
  input wire              reg_wr_i,
  input wire              reg_rd_i,
  input wire [15:0]       reg_rdata_o,
  input wire              output_block_input_1_i,
  input wire              output_block_input_2_i,
  input wire              motor2_select_pin_i,
  input wire              run_cmd_i,
  input wire              voltage_out_i,
  input wire              freq_out_i,
  input wire              dc_injection_i,
  input wire              baseblock_i,
  input wire [FREQ_W-1:0] output_freq_i,
  input wire              major_fault_i,
  input wire [7:0]        fault_code_i,
  input wire              output_a_pos_o,
  input wire              output_a_neg_o,
  input wire              output_b_pos_o,
  input wire              output_c_pos_o,
  input wire              motor2_active_o
);
  // Shadows of the selections, kept from the write strobes since the body is hidden
  reg  [7:0]  sel_a;
  reg  [7:0]  sel_b;
  reg  [7:0]  sel_c;
  reg  [1:0]  mode;
  reg  [2:0]  since_rst;
  wire [15:0] zero_level = mode[1] ? 16'h000A : (mode[0] ? 16'h0032 : 16'h0078);
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sel_a     <= 8'h00;
      sel_b     <= 8'h01;
      sel_c     <= 8'h02;
      mode      <= 2'h0;
      since_rst <= 3'h0;
    end else begin
      if (since_rst != 3'h7) since_rst <= since_rst + 3'h1;
      if (reg_wr_i && reg_addr_i == 3'h0) sel_a <= reg_wdata_i[7:0];
      if (reg_wr_i && reg_addr_i == 3'h1) sel_b <= reg_wdata_i[7:0];
      if (reg_wr_i && reg_addr_i == 3'h2) sel_c <= reg_wdata_i[7:0];
      if (reg_wr_i && reg_addr_i == 3'h3) mode <= reg_wdata_i[1:0];
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  a_sel_readback: assert property (reg_rd_i && reg_addr_i == 3'h0 |=>
    reg_rdata_o == {8'h00, sel_a}) else $error("selection readback wrong");
  a_run_route: assert property (sel_a == 8'h00 |=>
    output_a_pos_o == $past(run_cmd_i | voltage_out_i)) else $error("run output wrong");
  a_run2_route: assert property (sel_b == 8'h37 |=> output_b_pos_o ==
    $past(freq_out_i & !baseblock_i & !dc_injection_i)) else $error("run 2 output wrong");
  a_zero_level: assert property (sel_c == 8'h01 |=>
    output_c_pos_o == $past(output_freq_i < zero_level)) else $error("zero speed wrong");
  a_ready_drop: assert property (major_fault_i ##1 sel_a == 8'h06 |=>
    !output_a_pos_o) else $error("ready stays on after fault");
  a_fault_filter: assert property (sel_a == 8'h0E |=> output_a_pos_o == $past(
    major_fault_i && fault_code_i != CPU_FAULT_A && fault_code_i != CPU_FAULT_B))
    else $error("fault output wrong");
  a_block_pin: assert property (sel_b == 8'h1B [*4] |-> output_b_pos_o ==
    !($past(output_block_input_1_i, 3) | $past(output_block_input_2_i, 3)))
    else $error("block command output wrong");
  a_motor2_route: assert property (sel_c == 8'h1C |=>
    output_c_pos_o == $past(motor2_active_o)) else $error("motor 2 output wrong");
  a_motor2_flag: assert property (since_rst > 3'h2 |->
    motor2_active_o == $past(motor2_select_pin_i, 3)) else $error("motor 2 flag wrong");
  a_pair_complement: assert property (output_a_neg_o == !output_a_pos_o)
    else $error("terminal pair not complementary");
  a_unassigned_off: assert property (
    sel_b inside {8'h12, 8'h1E, 8'h30, 8'h33, 8'h44, 8'hFF} |=> !output_b_pos_o)
    else $error("unassigned code drives terminal");
endmodule // status_output_selector_monitor

bind status_output_selector status_output_selector_monitor #(.FREQ_W(FREQ_W),
  .CPU_FAULT_A(CPU_FAULT_A), .CPU_FAULT_B(CPU_FAULT_B)) monitor (.*);

/* File: status_output_selector_tb_top.sv */
// Self-checking bench for the status output selector
`timescale 1ns/100ps
module status_output_selector_tb_top;
  localparam [223:0] CODES = 224'h00_01_06_07_08_09_0A_0E_10_11_1A_1B_1C_1D_37_38_40_41_42_43_46_47_12_1E_30_33_44_FF;
  reg          clock_i, rst_b_i, reg_wr_i, reg_rd_i, chk, rdy;
  reg  [2:0]   reg_addr_i, ex;
  reg  [15:0]  reg_wdata_i, output_freq_i, motor_speed_i, thr;
  reg  [7:0]   fault_code_i, sa, sb, sc;
  reg  [1:0]   mode;
  reg  [17:0]  lv = 18'h0;
  reg  [3:0]   pins = 4'h0;
  wire         run_cmd_i, voltage_out_i, freq_out_i, dc_injection_i, baseblock_i, init_done_i;
  wire         undervoltage_i, fref_panel_i, run_src_panel_i, major_fault_i, minor_fault_i;
  wire         reverse_run_i, regen_i, brake_release_req_i, contactor_close_req_i;
  wire         fan_running_i, decel_i, travel_cmd_i, contact_a, motor2_active_o;
  wire         output_block_input_1_i, output_block_input_2_i, motor2_select_pin_i;
  wire         fault_reset_pin_i, output_a_pos_o, output_b_pos_o, output_c_pos_o;
  wire         output_a_neg_o, output_b_neg_o, output_c_neg_o;
  wire [15:0]  reg_rdata_o;
  integer      errors, check_count, i;
  integer      seed = 32'h75FB;
  assign {run_cmd_i, voltage_out_i, freq_out_i, dc_injection_i, baseblock_i, init_done_i,
          undervoltage_i, fref_panel_i, run_src_panel_i, major_fault_i, minor_fault_i,
          reverse_run_i, regen_i, brake_release_req_i, contactor_close_req_i,
          fan_running_i, decel_i, travel_cmd_i} = lv;
  assign {output_block_input_1_i, output_block_input_2_i, motor2_select_pin_i,
          fault_reset_pin_i} = pins;
  status_output_selector dut (.*);
  relay_contact_model relay (.pos_i(output_a_pos_o), .neg_i(output_a_neg_o), .closed_o(contact_a));
  function [7:0] code(input integer j);
    code = CODES[8*(27-j) +: 8];
  endfunction
  // Expected terminal level for a selection code from the present conditions
  function f(input [7:0] c);
    integer lev;
    begin
      lev = mode[1] ? 10 : (mode[0] ? 50 : 120);
      case (c)
        8'h00: f = run_cmd_i | voltage_out_i;
        8'h01: f = output_freq_i < lev;
        8'h06: f = rdy;
        8'h07: f = undervoltage_i;
        8'h08: f = baseblock_i;
        8'h09: f = fref_panel_i;
        8'h0A: f = run_src_panel_i;
        8'h0E: f = major_fault_i && fault_code_i != 8'h01 && fault_code_i != 8'h02;
        8'h10: f = minor_fault_i;
        8'h11: f = fault_reset_pin_i;
        8'h1A: f = reverse_run_i;
        8'h1B: f = !(output_block_input_1_i | output_block_input_2_i);
        8'h1C: f = motor2_select_pin_i;
        8'h1D: f = regen_i;
        8'h37: f = freq_out_i & !baseblock_i & !dc_injection_i;
        8'h38: f = fan_running_i;
        8'h40: f = brake_release_req_i;
        8'h41: f = contactor_close_req_i;
        8'h42: f = travel_cmd_i & decel_i & ((mode[1] ? motor_speed_i : output_freq_i) > thr);
        8'h43: f = !(output_freq_i < lev);
        8'h46: f = output_block_input_1_i & output_block_input_2_i;
        8'h47: f = !(output_block_input_1_i & output_block_input_2_i);
        default: f = 1'b0;
      endcase
    end
  endfunction
  task automatic cmp(input [8*10:1] nm, input [15:0] e, input [15:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("wrong value %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input [2:0] a, input [15:0] d);
    begin
      @(posedge clock_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge clock_i);
      reg_wr_i    <= 1'b0;
    end
  endtask
  task rd(input [2:0] a, input [15:0] e);
    begin
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge clock_i);
      reg_rd_i   <= 1'b0;
      @(negedge clock_i);
      cmp("read data", e, reg_rdata_o);
    end
  endtask
  task tally_and_finish;
    begin
      if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  always @(posedge clock_i) begin
    if (rst_b_i) begin
      lv            <= $random(seed);
      output_freq_i <= $random(seed) & 16'h00FF;
      motor_speed_i <= $random(seed) & 16'h00FF;
      fault_code_i  <= $random(seed) & 8'h03;
    end
  end
  // Model result of one edge is compared after the next edge has landed
  always @(negedge clock_i) begin
    if (chk) begin
      cmp("terminals", {13'h0, ex}, {13'h0, output_c_pos_o, output_b_pos_o, output_a_pos_o});
      cmp("pair negs", {13'h0, ~ex}, {13'h0, output_c_neg_o, output_b_neg_o, output_a_neg_o});
      cmp("motor2", {15'h0, motor2_select_pin_i}, {15'h0, motor2_active_o});
      cmp("relay a", {15'h0, ex[0]}, {15'h0, contact_a});
    end
    ex = {f(sc), f(sb), f(sa)};
    rdy = (!rst_b_i || major_fault_i) ? 1'b0 : (init_done_i ? 1'b1 : rdy);
  end
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    errors = errors + 1;
    tally_and_finish;
  end
  initial begin
    {errors, check_count, chk, rdy, ex, rst_b_i, reg_wr_i, reg_rd_i} = 0;
    {reg_addr_i, reg_wdata_i, output_freq_i, motor_speed_i, fault_code_i} = 0;
    {sa, sb, sc, mode, thr} = {8'h00, 8'h01, 8'h02, 2'h0, 16'h0064};
    repeat (20) @(posedge clock_i);
    rst_b_i <= 1'b1;
    rd(3'h0, 16'h0000);
    rd(3'h1, 16'h0001);
    rd(3'h2, 16'h0002);
    rd(3'h6, 16'h0000);
    wr(3'h4, thr);
    for (i = 0; i < 56; i = i + 1) begin
      chk  = 1'b0;
      sa   = code(i % 28);
      sb   = code((i + 9) % 28);
      sc   = code((i + 19) % 28);
      mode = i[5:4];
      wr(3'h0, {8'h00, sa});
      wr(3'h1, {8'h00, sb});
      wr(3'h2, {8'h00, sc});
      wr(3'h3, {14'h0, mode});
      pins <= i[3:0];
      rd(3'h0, {8'h00, sa});
      repeat (5) @(posedge clock_i);
      chk = 1'b1;
      repeat (12) @(posedge clock_i);
    end
    chk = 1'b0;
    rst_b_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    rst_b_i <= 1'b1;
    {sa, sb, sc, mode} = {8'h00, 8'h01, 8'h02, 2'h0};
    rd(3'h2, 16'h0002);
    tally_and_finish;
  end
endmodule // status_output_selector_tb_top
